// >>> inc/ddsb_if.sv
// Command link between the memory controller and the DDR device
`timescale 1ns/10ps
interface ddsb_if;
  import ddsb_pkg::*;
  logic link_clk;
  logic chip_sel_n;
  logic row_strobe_n;
  logic col_strobe_n;
  logic write_strobe_n;
  logic [BA_W-1:0] bank_sel;
  logic [ADDR_W-1:0] addr;

  modport ctrl (output link_clk, chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n, bank_sel, addr);
  modport dram (input link_clk, chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n, bank_sel, addr);
endinterface

// >>> inc/ddsb_pkg.sv
// Shared constants, types and command coding for the DDR bank command logic
package ddsb_pkg;

  localparam int REF_PERIOD_NS = 100;
  // Controller divides its reference clock by two to make the link clock
  localparam int LINK_DIV = 2;
  localparam int LINK_PERIOD_NS = REF_PERIOD_NS * LINK_DIV;

  // Bank timing in ns; plain defaults
  localparam int PRECHARGE_TIME_NS = 15;
  localparam int ACT_TO_COL_TIME_NS = 15;
  localparam int WRITE_RECOVERY_TIME_NS = 15;
  localparam int ROW_CYCLE_TIME_NS = 60;
  localparam int MODE_SET_TIME_NS = 20;

  localparam int CNT_W = 4;

  // Least times round up to whole link cycles, never below one
  function automatic int ns_to_cyc(input int t_ns);
    int c;
    c = (t_ns + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [CNT_W-1:0] PRECHARGE_CYC = CNT_W'(ns_to_cyc(PRECHARGE_TIME_NS));
  localparam logic [CNT_W-1:0] ACT_TO_COL_CYC = CNT_W'(ns_to_cyc(ACT_TO_COL_TIME_NS));
  localparam logic [CNT_W-1:0] WRITE_RECOVERY_CYC = CNT_W'(ns_to_cyc(WRITE_RECOVERY_TIME_NS));
  localparam logic [CNT_W-1:0] ROW_CYCLE_CYC = CNT_W'(ns_to_cyc(ROW_CYCLE_TIME_NS));
  localparam logic [CNT_W-1:0] MODE_SET_CYC = CNT_W'(ns_to_cyc(MODE_SET_TIME_NS));
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  // Two data beats per link cycle; a four-beat boundary is two cycles in
  localparam logic [CNT_W-1:0] BURST_CYC_BL4 = 4'h2;
  localparam logic [CNT_W-1:0] BURST_CYC_BL8 = 4'h4;
  localparam logic [CNT_W-1:0] BOUNDARY_LEFT = 4'h2;

  localparam int BANKS = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int AUTO_PRECHARGE_BIT = 10;
  localparam int MR_BL_LSB = 0;
  localparam int MR_BL_W = 3;
  localparam logic [MR_BL_W-1:0] MR_BL8_CODE = 3'h3;
  localparam logic [BA_W-1:0] MR_BANK = 3'h0;

  // Pin patterns {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n}
  localparam logic [3:0] PINS_DESELECT = 4'hF;
  localparam logic [3:0] PINS_NOP = 4'h7;
  localparam logic [3:0] PINS_READ = 4'h5;
  localparam logic [3:0] PINS_WRITE = 4'h4;
  localparam logic [3:0] PINS_ROW_OPEN = 4'h3;
  localparam logic [3:0] PINS_PRECHARGE = 4'h2;
  localparam logic [3:0] PINS_REFRESH = 4'h1;
  localparam logic [3:0] PINS_MODE = 4'h0;

  typedef enum logic [2:0] {
    DESELECT_CMD, NOP_CMD, READ_CMD, WRITE_CMD,
    ROW_OPEN_CMD, PRECHARGE_CMD, AUTO_REFRESH_CMD, MODE_REG_SET
  } ddsb_cmd_t;

  typedef enum logic [3:0] {
    BK_IDLE, BK_ROW_OPENING, BK_ACTIVE, BK_READ, BK_WRITE, BK_READ_AP,
    BK_WRITE_AP, BK_WR_RECOV, BK_WR_RECOV_AP, BK_PRECHARGING, BK_REFRESHING, BK_MODE_ACCESS
  } ddsb_bank_st_t;

  function automatic ddsb_cmd_t ddsb_decode(input logic [3:0] pins);
    ddsb_cmd_t c;
    c = DESELECT_CMD;
    if (pins == PINS_NOP) c = NOP_CMD;
    else if (pins == PINS_READ) c = READ_CMD;
    else if (pins == PINS_WRITE) c = WRITE_CMD;
    else if (pins == PINS_ROW_OPEN) c = ROW_OPEN_CMD;
    else if (pins == PINS_PRECHARGE) c = PRECHARGE_CMD;
    else if (pins == PINS_REFRESH) c = AUTO_REFRESH_CMD;
    else if (pins == PINS_MODE) c = MODE_REG_SET;
    return c;
  endfunction

  function automatic logic [3:0] ddsb_encode(input ddsb_cmd_t c);
    logic [3:0] p;
    p = PINS_DESELECT;
    unique case (c)
      DESELECT_CMD: p = PINS_DESELECT;
      NOP_CMD: p = PINS_NOP;
      READ_CMD: p = PINS_READ;
      WRITE_CMD: p = PINS_WRITE;
      ROW_OPEN_CMD: p = PINS_ROW_OPEN;
      PRECHARGE_CMD: p = PINS_PRECHARGE;
      AUTO_REFRESH_CMD: p = PINS_REFRESH;
      MODE_REG_SET: p = PINS_MODE;
    endcase
    return p;
  endfunction

endpackage

// >>> rtl/ddsb_bank.sv
// One bank: legality of the presented command and timed state transitions
`timescale 1ns/10ps
module ddsb_bank
  import ddsb_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Command presented to this bank
  input wire logic i_step,
  input wire logic i_accept,
  input wire ddsb_cmd_t i_cmd,
  input wire logic i_hit,
  input wire logic i_ap,
  input wire logic i_bl8,
  // Bank view
  output logic o_legal,
  output logic o_idle,
  output ddsb_bank_st_t o_state
);

  typedef struct packed {
    ddsb_bank_st_t st;
    logic [CNT_W-1:0] cnt;
  } ddsb_bank_reg_t;

  ddsb_bank_reg_t r;
  ddsb_bank_reg_t next_r;
  logic nop_like;
  logic on_boundary;
  logic applies;
  logic [CNT_W-1:0] burst_len;

  always_comb
  begin
    nop_like = (i_cmd == DESELECT_CMD) || (i_cmd == NOP_CMD);
    on_boundary = i_bl8 && (r.cnt == BOUNDARY_LEFT);
    // The command edge is the first burst cycle, so the count left starts one short
    burst_len = (i_bl8 ? BURST_CYC_BL8 : BURST_CYC_BL4) - CNT_ONE;
    unique case (r.st)
      BK_IDLE: o_legal = i_cmd inside {ROW_OPEN_CMD, PRECHARGE_CMD, AUTO_REFRESH_CMD, MODE_REG_SET};
      BK_ACTIVE: o_legal = i_cmd inside {READ_CMD, WRITE_CMD, PRECHARGE_CMD};
      BK_READ: o_legal = (i_cmd == READ_CMD) && on_boundary;
      BK_WRITE: o_legal = (i_cmd == WRITE_CMD) && on_boundary;
      BK_PRECHARGING: o_legal = (i_cmd == PRECHARGE_CMD);
      BK_WR_RECOV: o_legal = (i_cmd == WRITE_CMD);
      default: o_legal = 1'b0;
    endcase
    // Refresh and mode access lock every bank, whichever bank is named
    if (nop_like)
      o_legal = 1'b1;
    else if (!i_hit && !(r.st inside {BK_REFRESHING, BK_MODE_ACCESS}))
      o_legal = 1'b1;
    // A precharge to a bank that is idle or already precharging changes nothing
    applies = i_accept && i_hit && !nop_like && !((i_cmd == PRECHARGE_CMD) && (r.st != BK_ACTIVE));
    next_r = r;
    if (i_step)
    begin
      if (applies)
      begin
        unique case (i_cmd)
          ROW_OPEN_CMD: next_r = '{st: BK_ROW_OPENING, cnt: ACT_TO_COL_CYC};
          READ_CMD: next_r = '{st: i_ap ? BK_READ_AP : BK_READ, cnt: burst_len};
          WRITE_CMD: next_r = '{st: i_ap ? BK_WRITE_AP : BK_WRITE, cnt: burst_len};
          PRECHARGE_CMD: next_r = '{st: BK_PRECHARGING, cnt: PRECHARGE_CYC};
          AUTO_REFRESH_CMD: next_r = '{st: BK_REFRESHING, cnt: ROW_CYCLE_CYC};
          MODE_REG_SET: next_r = '{st: BK_MODE_ACCESS, cnt: MODE_SET_CYC};
          default: next_r = r;
        endcase
      end
      else if (r.cnt > CNT_ONE)
        next_r.cnt = r.cnt - CNT_ONE;
      else
      begin
        unique case (r.st)
          BK_ROW_OPENING: next_r.st = BK_ACTIVE;
          BK_READ: next_r.st = BK_ACTIVE;
          BK_WRITE: next_r = '{st: BK_WR_RECOV, cnt: WRITE_RECOVERY_CYC};
          BK_READ_AP: next_r = '{st: BK_PRECHARGING, cnt: PRECHARGE_CYC};
          BK_WRITE_AP: next_r = '{st: BK_WR_RECOV_AP, cnt: WRITE_RECOVERY_CYC};
          BK_WR_RECOV: next_r.st = BK_ACTIVE;
          BK_WR_RECOV_AP: next_r = '{st: BK_PRECHARGING, cnt: PRECHARGE_CYC};
          BK_PRECHARGING: next_r.st = BK_IDLE;
          BK_REFRESHING: next_r.st = BK_IDLE;
          BK_MODE_ACCESS: next_r.st = BK_IDLE;
          default: next_r = r;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      r <= '{st: BK_IDLE, cnt: CNT_ONE};
    else
      r <= next_r;
  end

  assign o_idle = (r.st == BK_IDLE);
  assign o_state = r.st;

endmodule

// >>> rtl/ddsb_ctrl.sv
// Controller end: makes the link clock and issues only legal commands
`timescale 1ns/10ps
module ddsb_ctrl
  import ddsb_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Command request
  input wire logic i_req_valid,
  input wire ddsb_cmd_t i_req_cmd,
  input wire logic [BA_W-1:0] i_req_bank,
  input wire logic [ADDR_W-1:0] i_req_addr,
  output logic o_req_ready,
  // Status
  output logic o_issued,
  output logic o_all_idle,
  output logic o_bl8,
  output logic [BANKS-1:0] o_bank_idle,
  // Command link to the device
  ddsb_if.ctrl lnk
);

  typedef struct packed {
    logic link_clk;
    logic [3:0] pins;
    logic [BA_W-1:0] bank_sel;
    logic [ADDR_W-1:0] addr;
    logic issued;
    logic bl8;
    logic all_idle;
  } ddsb_ctrl_reg_t;

  ddsb_ctrl_reg_t r;
  ddsb_ctrl_reg_t next_r;
  logic slot;
  logic legal_all;
  logic take;
  logic [BANKS-1:0] legal;
  logic [BANKS-1:0] idle;
  logic [BANKS-1:0] hit;

  // Pins change as the link clock falls, half a period before the device samples
  assign slot = r.link_clk;

  // The trackers mirror the device banks, stepped once per link period
  genvar b;
  generate
    for (b = 0; b < BANKS; b++)
    begin : g_track
      assign hit[b] = (i_req_cmd inside {AUTO_REFRESH_CMD, MODE_REG_SET})
        || ((i_req_cmd == PRECHARGE_CMD) && i_req_addr[AUTO_PRECHARGE_BIT])
        || (i_req_bank == BA_W'(b));
      ddsb_bank u_track (
        .i_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_step(slot),
        .i_accept(take),
        // Accept gates the update; folding take into the command would loop through legality
        .i_cmd(i_req_cmd),
        .i_hit(hit[b]),
        .i_ap(i_req_addr[AUTO_PRECHARGE_BIT]),
        .i_bl8(r.bl8),
        .o_legal(legal[b]),
        .o_idle(idle[b]),
        .o_state()
      );
    end
  endgenerate

  // Legality of the request, judged by every bank at once
  always_comb
  begin
    legal_all = &legal;
    if (i_req_cmd inside {AUTO_REFRESH_CMD, MODE_REG_SET})
      legal_all = legal_all && (&idle);
  end

  // Trackers only see the request when it is really issued
  assign take = slot && i_req_valid && legal_all;

  // A refused request is held off by ready, never sent
  assign o_req_ready = slot && legal_all;

  always_comb
  begin
    next_r = r;
    next_r.link_clk = ~r.link_clk;
    next_r.issued = 1'b0;
    if (slot)
    begin
      if (take)
      begin
        next_r.pins = ddsb_encode(i_req_cmd);
        next_r.bank_sel = i_req_bank;
        next_r.addr = i_req_addr;
        next_r.issued = 1'b1;
        if ((i_req_cmd == MODE_REG_SET) && (i_req_bank == MR_BANK))
          next_r.bl8 = (i_req_addr[MR_BL_LSB +: MR_BL_W] == MR_BL8_CODE);
      end
      else
        next_r.pins = PINS_NOP;
    end
    next_r.all_idle = &idle;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      r <= '{link_clk: 1'b0, pins: PINS_DESELECT, bank_sel: '0, addr: '0, issued: 1'b0, bl8: 1'b0,
             all_idle: 1'b1};
    else
      r <= next_r;
  end

  // Device registers one command per rising link edge
  assign lnk.link_clk = r.link_clk;
  assign lnk.chip_sel_n = r.pins[3];
  assign lnk.row_strobe_n = r.pins[2];
  assign lnk.col_strobe_n = r.pins[1];
  assign lnk.write_strobe_n = r.pins[0];
  assign lnk.bank_sel = r.bank_sel;
  assign lnk.addr = r.addr;

  assign o_issued = r.issued;
  assign o_all_idle = r.all_idle;
  assign o_bl8 = r.bl8;
  assign o_bank_idle = idle;

endmodule

// >>> rtl/ddsb_dram.sv
// Device end: samples the command pins on the link clock and tracks all banks
`timescale 1ns/10ps
module ddsb_dram
  import ddsb_pkg::*;
(
  // Command link from the controller
  ddsb_if.dram lnk,
  // Reference clock and reset for the status side
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Status in the reference domain
  output logic o_illegal,
  output logic o_all_idle,
  output logic o_bl8
);

  typedef struct packed {
    logic ill_tgl;
    logic bl8;
    logic all_idle;
  } ddsb_link_reg_t;

  typedef struct packed {
    logic [2:0] ill_s;
    logic [2:0] idle_s;
    logic [2:0] bl8_s;
    logic ill_acc;
    logic illegal;
    logic all_idle;
    logic bl8;
  } ddsb_ref_reg_t;

  ddsb_link_reg_t l;
  ddsb_link_reg_t next_l;
  ddsb_ref_reg_t q;
  ddsb_ref_reg_t next_q;
  ddsb_cmd_t cmd;
  logic [BANKS-1:0] legal;
  logic [BANKS-1:0] idle;
  logic [BANKS-1:0] hit;
  logic accept;

  // Pins are synchronous to the link clock; the command of each edge is acted on at that edge
  assign cmd = ddsb_decode({lnk.chip_sel_n, lnk.row_strobe_n, lnk.col_strobe_n, lnk.write_strobe_n});
  assign accept = &legal;

  genvar b;
  generate
    for (b = 0; b < BANKS; b++)
    begin : g_bank
      assign hit[b] = (cmd inside {AUTO_REFRESH_CMD, MODE_REG_SET})
        || ((cmd == PRECHARGE_CMD) && lnk.addr[AUTO_PRECHARGE_BIT])
        || (lnk.bank_sel == BA_W'(b));
      ddsb_bank u_bank (
        .i_clk(lnk.link_clk),
        .i_nrst(i_nrst),
        .i_step(1'b1),
        .i_accept(accept),
        .i_cmd(cmd),
        .i_hit(hit[b]),
        .i_ap(lnk.addr[AUTO_PRECHARGE_BIT]),
        .i_bl8(l.bl8),
        .o_legal(legal[b]),
        .o_idle(idle[b]),
        .o_state()
      );
    end
  endgenerate

  always_comb
  begin
    next_l = l;
    // An illegal command is ignored by every bank and only reported
    if (!accept)
      next_l.ill_tgl = ~l.ill_tgl;
    if (accept && (cmd == MODE_REG_SET) && (lnk.bank_sel == MR_BANK))
      next_l.bl8 = (lnk.addr[MR_BL_LSB +: MR_BL_W] == MR_BL8_CODE);
    next_l.all_idle = &idle;
  end

  always_ff @(posedge lnk.link_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      l <= '0;
    else
      l <= next_l;
  end

  // Toggle and levels cross on three flops; two illegal commands closer than
  // about two reference cycles cancel and raise no report
  always_comb
  begin
    next_q = q;
    next_q.ill_s = {q.ill_s[1:0], l.ill_tgl};
    next_q.idle_s = {q.idle_s[1:0], l.all_idle};
    next_q.bl8_s = {q.bl8_s[1:0], l.bl8};
    next_q.illegal = 1'b0;
    if ((q.ill_s[1] == q.ill_s[2]) && (q.ill_s[2] != q.ill_acc))
    begin
      next_q.illegal = 1'b1;
      next_q.ill_acc = q.ill_s[2];
    end
    if (q.idle_s[1] == q.idle_s[2])
      next_q.all_idle = q.idle_s[2];
    if (q.bl8_s[1] == q.bl8_s[2])
      next_q.bl8 = q.bl8_s[2];
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      q <= '0;
    else
      q <= next_q;
  end

  assign o_illegal = q.illegal;
  assign o_all_idle = q.all_idle;
  assign o_bl8 = q.bl8;

endmodule

// >>> verification/ddsb_properties.sv
// Concurrent checks on the command link between controller and device
`timescale 1ns/10ps
module ddsb_properties
  import ddsb_pkg::*;
(
  // Clocks and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Command link
  input wire logic link_clk,
  input wire logic chip_sel_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [BA_W-1:0] bank_sel,
  input wire logic [ADDR_W-1:0] addr
);
  logic [3:0] pins;
  logic rd, wr, opn, pre, rfs, mode_reg_set, col, hit_prev, bl8;
  logic [BA_W-1:0] prev_bank;
  assign pins = {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n};
  assign rd = (pins == PINS_READ);
  assign wr = (pins == PINS_WRITE);
  assign opn = (pins == PINS_ROW_OPEN);
  assign pre = (pins == PINS_PRECHARGE);
  assign rfs = (pins == PINS_REFRESH);
  assign mode_reg_set = (pins == PINS_MODE);
  assign col = rd | wr;
  assign hit_prev = ((col | opn | pre) & (bank_sel == prev_bank)) | (pre & addr[AUTO_PRECHARGE_BIT]) | rfs | mode_reg_set;

  // Burst length is tracked from the pins, so no view into the device is needed
  always_ff @(posedge link_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bl8 <= 1'b0;
      prev_bank <= '0;
    end
    else
    begin
      prev_bank <= bank_sel;
      if (mode_reg_set && (bank_sel == MR_BANK))
        bl8 <= (addr[MR_BL_LSB +: MR_BL_W] == MR_BL8_CODE);
    end
  end

  AST_PINS_HOLD: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(link_clk) |-> $stable({pins, bank_sel, addr}))
    else $error("command pins moved at a link clock rise");
  AST_LINK_DIV: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(link_clk) |=> $fell(link_clk) ##1 $rose(link_clk))
    else $error("link clock is not the reference clock halved");
  AST_AP_LOCK: assert property (@(posedge link_clk) disable iff (!i_nrst)
    col && addr[AUTO_PRECHARGE_BIT] |=> !hit_prev)
    else $error("auto-precharge burst hit by a command");
  AST_BL4_WHOLE: assert property (@(posedge link_clk) disable iff (!i_nrst)
    col && !bl8 |=> !hit_prev)
    else $error("length four burst interrupted");
  AST_BL8_BOUNDARY: assert property (@(posedge link_clk) disable iff (!i_nrst)
    col && bl8 |-> ##1 !hit_prev ##2 !(col && (bank_sel == $past(bank_sel, 3))))
    else $error("length eight burst interrupted off the boundary");
  AST_NO_CROSS: assert property (@(posedge link_clk) disable iff (!i_nrst)
    wr && bl8 |-> !($past(rd, 2) && ($past(bank_sel, 2) == bank_sel)))
    else $error("write interrupts a read burst");
  AST_OPEN_WAIT: assert property (@(posedge link_clk) disable iff (!i_nrst)
    opn |=> !(opn && (bank_sel == prev_bank)) && !rfs && !mode_reg_set)
    else $error("command to a bank still activating");
  AST_REF_IDLE: assert property (@(posedge link_clk) disable iff (!i_nrst)
    (rfs || mode_reg_set) |-> !$past(col))
    else $error("refresh or mode set while a burst runs");

  COV_BL8_INT: cover property (@(posedge link_clk) disable iff (!i_nrst) col && bl8 ##2 col);
  COV_AP: cover property (@(posedge link_clk) disable iff (!i_nrst) col && addr[AUTO_PRECHARGE_BIT]);
  COV_MODE: cover property (@(posedge link_clk) disable iff (!i_nrst) mode_reg_set);
endmodule

// >>> verification/testbench.sv
// Bench for both link ends plus a device driven directly with faulty commands
`timescale 1ns/10ps
module testbench;
  import ddsb_pkg::*;
  typedef struct {logic opn; logic [3:0] p1; logic [13:0] a1; int gap; logic [3:0] p2; logic [2:0] b2; logic ill;}
    ddsb_case_t;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic req_valid = 1'b0;
  ddsb_cmd_t req_cmd = NOP_CMD;
  logic [BA_W-1:0] req_bank = '0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic req_ready, issued, c_idle, c_bl8, d_ill, d_idle, d_bl8, b_ill, b_idle, b_bl8;
  logic [BANKS-1:0] bank_idle;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  int ill_a = 0;
  int ill_b = 0;
  int t0, t1, n0;
  ddsb_case_t tbl [9] = '{
    '{1'b1, PINS_READ, 14'h0400, 0, PINS_ROW_OPEN, 3'h0, 1'b1},
    '{1'b1, PINS_WRITE, 14'h0000, 0, PINS_WRITE, 3'h0, 1'b1},
    '{1'b1, PINS_READ, 14'h0000, 0, PINS_WRITE, 3'h0, 1'b1},
    '{1'b1, PINS_NOP, 14'h0000, 0, PINS_REFRESH, 3'h0, 1'b1},
    '{1'b1, PINS_PRECHARGE, 14'h0000, 0, PINS_PRECHARGE, 3'h0, 1'b0},
    '{1'b1, PINS_READ, 14'h0000, 0, PINS_ROW_OPEN, 3'h3, 1'b0},
    '{1'b1, PINS_WRITE, 14'h0000, 1, PINS_WRITE, 3'h0, 1'b0},
    '{1'b1, PINS_READ, 14'h0000, 0, PINS_READ, 3'h0, 1'b1},
    '{1'b1, PINS_READ, 14'h0000, 1, PINS_READ, 3'h0, 1'b0}};
  ddsb_if lnk();
  ddsb_if lnk_b();
  ddsb_ctrl u_ddsb_ctrl (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_req_valid(req_valid), .i_req_cmd(req_cmd),
    .i_req_bank(req_bank), .i_req_addr(req_addr), .o_req_ready(req_ready), .o_issued(issued),
    .o_all_idle(c_idle), .o_bl8(c_bl8), .o_bank_idle(bank_idle), .lnk(lnk));
  ddsb_dram u_ddsb_dram (.lnk(lnk), .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .o_illegal(d_ill),
    .o_all_idle(d_idle), .o_bl8(d_bl8));
  ddsb_dram u_ddsb_dram_b (.lnk(lnk_b), .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .o_illegal(b_ill),
    .o_all_idle(b_idle), .o_bl8(b_bl8));
  ddsb_properties u_ddsb_properties (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .link_clk(lnk.link_clk),
    .chip_sel_n(lnk.chip_sel_n), .row_strobe_n(lnk.row_strobe_n), .col_strobe_n(lnk.col_strobe_n),
    .write_strobe_n(lnk.write_strobe_n), .bank_sel(lnk.bank_sel), .addr(lnk.addr));

  initial
    forever #50 i_ref_clk = ~i_ref_clk;
  // Second device link runs free at its own rate, out of phase with the reference
  initial
  begin
    {lnk_b.chip_sel_n, lnk_b.row_strobe_n, lnk_b.col_strobe_n, lnk_b.write_strobe_n} = PINS_DESELECT;
    lnk_b.bank_sel = '0;
    lnk_b.addr = '0;
    lnk_b.link_clk = 1'b0;
    #13;
    forever #40 lnk_b.link_clk = ~lnk_b.link_clk;
  end
  always @(posedge i_ref_clk)
    cyc <= cyc + 1;
  // Flag pulses last one reference cycle, so the falling edge sees each one
  always @(negedge i_ref_clk)
  begin
    if (d_ill === 1'b1)
      ill_a <= ill_a + 1;
    if (b_ill === 1'b1)
      ill_b <= ill_b + 1;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Hold the request until ready is seen high at a rising edge
  task automatic req(input ddsb_cmd_t c, input logic [2:0] b, input logic [13:0] a);
    int n;
    n = 0;
    @(negedge i_ref_clk);
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    #1;
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(negedge i_ref_clk);
      #1;
      n++;
    end
    chk1(req_ready, 1'b1);
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    t1 = cyc;
    req_valid = 1'b0;
    chk1(issued, 1'b1);
  endtask
  task automatic refuse(input ddsb_cmd_t c, input logic [2:0] b);
    @(negedge i_ref_clk);
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    repeat (8)
    begin
      #1;
      chk1(req_ready, 1'b0);
      @(negedge i_ref_clk);
    end
    req_valid = 1'b0;
  endtask
  task automatic send(input logic [3:0] p, input logic [2:0] b, input logic [13:0] a);
    @(negedge lnk_b.link_clk);
    {lnk_b.chip_sel_n, lnk_b.row_strobe_n, lnk_b.col_strobe_n, lnk_b.write_strobe_n} = p;
    lnk_b.bank_sel = b;
    lnk_b.addr = a;
  endtask
  // Address is don't-care on a NOP, so it toggles rather than keeping a stale value
  task automatic nops(input int n);
    repeat (n) send(PINS_NOP, ~lnk_b.bank_sel, ~lnk_b.addr);
  endtask

  initial
  begin
    repeat (4) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    repeat (12) @(negedge i_ref_clk);
    chk1(c_idle, 1'b1);
    chkv(32'(bank_idle), 32'h0000_00FF);
    chk1(d_idle, 1'b1);
    $display("test reset done");
    req(MODE_REG_SET, MR_BANK, 14'h0003);
    repeat (10) @(negedge i_ref_clk);
    chk1(c_bl8, 1'b1);
    chk1(d_bl8, 1'b1);
    req(ROW_OPEN_CMD, 3'h1, 14'h0000);
    refuse(AUTO_REFRESH_CMD, 3'h0);
    chk1(bank_idle[1], 1'b0);
    req(READ_CMD, 3'h1, 14'h0000);
    t0 = t1;
    req(READ_CMD, 3'h1, 14'h0000);
    chkv(32'(t1 - t0), 32'h0000_0004);
    req(WRITE_CMD, 3'h1, 14'h0000);
    req(PRECHARGE_CMD, 3'h0, 14'h0400);
    req(MODE_REG_SET, MR_BANK, 14'h0002);
    req(ROW_OPEN_CMD, 3'h2, 14'h0000);
    req(READ_CMD, 3'h2, 14'h0400);
    req(ROW_OPEN_CMD, 3'h2, 14'h0000);
    chk1(bank_idle[2], 1'b0);
    req(PRECHARGE_CMD, 3'h0, 14'h0400);
    req(AUTO_REFRESH_CMD, 3'h0, 14'h0000);
    chkv(32'(bank_idle), 32'h0000_0000);
    repeat (10) @(negedge i_ref_clk);
    chk1(c_bl8, 1'b0);
    chkv(32'(bank_idle), 32'h0000_00FF);
    chkv(32'(ill_a), 32'h0000_0000);
    $display("test controller done");
    for (int i = 0; i < 9; i++)
    begin
      if (i == 7)
      begin
        send(PINS_MODE, 3'h1, 14'h0003);
        nops(10);
        chk1(b_bl8, 1'b0);
        send(PINS_MODE, MR_BANK, 14'h0003);
        nops(10);
        chk1(b_bl8, 1'b1);
      end
      n0 = ill_b;
      if (tbl[i].opn)
      begin
        send(PINS_ROW_OPEN, 3'h0, 14'h0000);
        nops(4);
      end
      send(tbl[i].p1, 3'h0, tbl[i].a1);
      nops(tbl[i].gap);
      send(tbl[i].p2, tbl[i].b2, 14'h0000);
      nops(12);
      chk1(ill_b != n0, tbl[i].ill);
      send(PINS_PRECHARGE, 3'h0, 14'h0400);
      nops(10);
      chk1(b_idle, 1'b1);
    end
    $display("test device done");
    finish_test();
  end

  initial
  begin
    #200000;
    mismatches++;
    $display("watchdog expired");
    finish_test();
  end
endmodule
